// ### design/arc_ctrl_regs.sv
// Operation
// RULE1: The current-sense measurement time is 768 us, 1.536 ms, 3.072 ms or 12.288 ms for selector 00 to 11.
// RULE2: The shunt filter enable routes shunt readings only through the post-conversion low-pass filter.
// RULE3: The cell filter enable routes cell voltage readings only through the post-conversion low-pass filter.
// RULE4: Writing 1 to the start bit begins a conversion that samples all main converter inputs.
// RULE5: Control settings written after a start take effect only at the next write of 1 to the start bit.
// RULE6: The start bit clears to 0 when read.
// RULE7: Writing 0 to the start bit has no effect.
// RULE8: Start and run mode drive the current-sense converter together with the main converter.
// RULE9: Run mode 00 stops, 01 runs eight round robins then stops, 10 runs until stopped, 11 is reserved.
// RULE10: The detach bit set disconnects the main converter shunt front end; clear keeps it connected.
// RULE11: Alignment 0 places the auxiliary cell measurement on the main first cell slot; 1 is reserved.
// RULE12: Selector 0x00 cycles the auxiliary converter through all active cell channels.
// RULE13: Selector 0x01 keeps the shunt pins off the auxiliary converter.
// RULE14: Selectors 0x02 to 0x07 lock the auxiliary converter to cell channel one to six.
// RULE15: An inactive channel or reserved code skips the auxiliary conversion in that slot.
// RULE16: Reserved bits read 0 and ignore writes, and all fields reset to 0 leaving both converters idle.
`timescale 1ns/1ps
`default_nettype none
module arc_ctrl_regs #(
  parameter int unsigned ISENSE_CYC00 = arc_pkg::ISENSE_CYC00,
  parameter int unsigned ISENSE_CYC01 = arc_pkg::ISENSE_CYC01,
  parameter int unsigned ISENSE_CYC10 = arc_pkg::ISENSE_CYC10,
  parameter int unsigned ISENSE_CYC11 = arc_pkg::ISENSE_CYC11
) (
  input  wire logic           clk_in,
  input  wire logic           sys_rst_in,
  input  wire logic           hsel_in,
  input  wire logic [31:0]    haddr_in,
  input  wire logic [1:0]     htrans_in,
  input  wire logic           hwrite_in,
  input  wire logic [2:0]     hsize_in,
  input  wire logic [31:0]    hwdata_in,
  input  wire logic           hready_in,
  output logic [31:0]         hrdata_out,
  output logic                hreadyout_out,
  output logic                hresp_out,
  input  wire logic [5:0]     active_cell_cfg_in,
  input  wire logic           main_rr_done_in,
  input  wire logic           main_cell1_slot_in,
  output arc_pkg::arc_conv_cfg_s conv_cfg_out,
  output logic                main_start_out,
  output logic                main_running_out,
  output logic                isense_start_out,
  output logic                isense_running_out,
  output logic                isense_sample_out,
  output logic                aux_start_out,
  output logic [2:0]          aux_cell_chan_out,
  output logic                aux_skip_out
);
  import arc_pkg::*;

  default clocking dflt_cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);

  function automatic logic hit(input logic ok, input logic [11:0] idx, input logic [11:0] tgt);
    return ok && (idx == tgt);
  endfunction

  function automatic logic [CHAN_W-1:0] next_active(input logic [CHAN_W-1:0] cur,
                                                    input logic [NUM_CELLS-1:0] mask);
    logic [CHAN_W-1:0] res;
    int                c;
    res = '0;
    for (int i = NUM_CELLS; i >= 1; i--) begin
      c = int'(cur) + i;
      if (c > NUM_CELLS) begin
        c = c - NUM_CELLS;
      end
      if (mask[c-1]) begin
        res = CHAN_W'(c);
      end
    end
    return res;
  endfunction
  logic           a_acc;
  logic           a_rd;
  logic           a_ok;
  logic [11:0]    a_idx;
  logic           dp_wr_d;
  logic           dp_wr_q;
  logic           dp_ok_d;
  logic           dp_ok_q;
  logic [11:0]    dp_idx_d;
  logic [11:0]    dp_idx_q;
  logic [31:0]    rdata_d;
  logic [31:0]    rdata_q;
  logic           wr_main;
  logic           wr_aux;
  logic           go;
  logic           rd_main;
  arc_main_ctrl_s main_fwd;
  arc_main_ctrl_s main_d;
  arc_main_ctrl_s main_q;
  arc_aux_ctrl_s  aux_fwd;
  arc_aux_ctrl_s  aux_d;
  arc_aux_ctrl_s  aux_q;
  arc_status_s    status;
  arc_main_ctrl_s act_main_d;
  arc_main_ctrl_s act_main_q;
  arc_aux_ctrl_s  act_aux_d;
  arc_aux_ctrl_s  act_aux_q;
  logic           run_d;
  logic           run_q;
  logic           start_d;
  logic           start_q;
  logic           iso_d;
  logic           iso_q;
  logic [3:0]     rr_d;
  logic [3:0]     rr_q;
  logic [2:0]     ptr_d;
  logic [2:0]     ptr_q;
  logic [2:0]     chan_d;
  logic [2:0]     chan_q;
  logic           astart_d;
  logic           astart_q;
  logic           skip_d;
  logic           skip_q;
  logic [2:0]     cand;
  logic [4:0]     sel_ofs;
  assign status = '{aux_chan: chan_q, rr_cnt: rr_q, running: run_q};

  always_comb begin
    a_acc    = hsel_in && hready_in && htrans_in[1];
    a_rd     = a_acc && !hwrite_in;
    a_ok     = (haddr_in[31:14] == '0);
    a_idx    = haddr_in[13:2];
    dp_wr_d  = a_acc && hwrite_in;
    dp_ok_d  = a_ok;
    dp_idx_d = a_idx;
    wr_main  = dp_wr_q && hit(dp_ok_q, dp_idx_q, MAIN_CTRL_IDX);
    wr_aux   = dp_wr_q && hit(dp_ok_q, dp_idx_q, AUX_CTRL_IDX);
    go       = wr_main && hwdata_in[START_BIT]; // RULE4
    rd_main  = a_rd && hit(a_ok, a_idx, MAIN_CTRL_IDX);
    main_fwd = main_q;
    if (wr_main) begin
      main_fwd = arc_main_ctrl_s'(hwdata_in[7:0] & CTRL_WMASK); // RULE16
    end
    // Writing 0 leaves a pending start in place
    main_fwd.start = main_q.start || go; // RULE7
    aux_fwd = wr_aux ? arc_aux_ctrl_s'(hwdata_in[7:0] & CTRL_WMASK) : aux_q; // RULE16
    main_d       = main_fwd;
    main_d.start = go || (main_q.start && !rd_main); // RULE6
    aux_d        = aux_fwd;
    // Read data forwarded from a write still in its data phase
    rdata_d = '0;
    if (a_rd && a_ok) begin
      case (a_idx)
        MAIN_CTRL_IDX: rdata_d[7:0] = main_fwd;
        AUX_CTRL_IDX:  rdata_d[7:0] = aux_fwd;
        STATUS_IDX:    rdata_d[7:0] = status;
        default:       rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      dp_wr_q  <= 1'b0;
      dp_ok_q  <= 1'b0;
      dp_idx_q <= '0;
      rdata_q  <= '0;
      main_q   <= arc_main_ctrl_s'(MAIN_CTRL_RST); // RULE16
      aux_q    <= arc_aux_ctrl_s'(AUX_CTRL_RST);
    end else begin
      dp_wr_q  <= dp_wr_d;
      dp_ok_q  <= dp_ok_d;
      dp_idx_q <= dp_idx_d;
      rdata_q  <= rdata_d;
      main_q   <= main_d;
      aux_q    <= aux_d;
    end
  end

  always_comb begin
    act_main_d = act_main_q;
    act_aux_d  = act_aux_q;
    run_d      = run_q;
    rr_d       = rr_q;
    iso_d      = iso_q;
    start_d    = go; // RULE8
    if (go) begin
      // Settings are captured only here
      act_main_d = main_fwd; // RULE5
      act_aux_d  = aux_fwd;
      iso_d      = (aux_fwd.aux_cell_chan_sel == AUX_SEL_NOSHUNT); // RULE13
      run_d      = main_fwd.run_mode inside {MODE_SINGLE, MODE_CONT}; // RULE9
      rr_d       = '0;
    end else if (run_q && main_rr_done_in && act_main_q.run_mode == MODE_SINGLE) begin
      rr_d = rr_q + 1'b1;
      if (rr_d == RR_SINGLE_RUNS) begin
        run_d = 1'b0; // RULE9
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      act_main_q <= arc_main_ctrl_s'(MAIN_CTRL_RST);
      act_aux_q  <= arc_aux_ctrl_s'(AUX_CTRL_RST);
      run_q      <= 1'b0; // RULE16
      rr_q       <= '0;
      iso_q      <= 1'b0;
      start_q    <= 1'b0;
    end else begin
      act_main_q <= act_main_d;
      act_aux_q  <= act_aux_d;
      run_q      <= run_d;
      rr_q       <= rr_d;
      iso_q      <= iso_d;
      start_q    <= start_d;
    end
  end

  // Alignment value 1 is reserved and treated as first-cell alignment
  always_comb begin
    ptr_d    = ptr_q;
    chan_d   = chan_q;
    astart_d = 1'b0;
    skip_d   = 1'b0;
    cand     = '0;
    sel_ofs  = act_aux_q.aux_cell_chan_sel - AUX_SEL_FIRST + AUX_SEL_STEP;
    if (go) begin
      ptr_d = '0;
    end else if (run_q && main_cell1_slot_in) begin // RULE11
      if (act_aux_q.aux_cell_chan_sel == AUX_SEL_CYCLE) begin
        cand = next_active(ptr_q, active_cell_cfg_in); // RULE12
      end else if (act_aux_q.aux_cell_chan_sel >= AUX_SEL_FIRST &&
                   act_aux_q.aux_cell_chan_sel <= AUX_SEL_LAST) begin
        cand = sel_ofs[2:0]; // RULE14
        if (!active_cell_cfg_in[cand-3'h1]) begin
          cand = '0; // RULE15
        end
      end
      if (cand != '0) begin
        astart_d = 1'b1;
        chan_d   = cand;
        ptr_d    = cand;
      end else begin
        skip_d = 1'b1; // RULE15
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      ptr_q    <= '0;
      chan_q   <= '0;
      astart_q <= 1'b0;
      skip_q   <= 1'b0;
    end else begin
      ptr_q    <= ptr_d;
      chan_q   <= chan_d;
      astart_q <= astart_d;
      skip_q   <= skip_d;
    end
  end

  arc_isense_timer #(
    .CYC00 (ISENSE_CYC00),
    .CYC01 (ISENSE_CYC01),
    .CYC10 (ISENSE_CYC10),
    .CYC11 (ISENSE_CYC11)
  ) u_timer (
    .clk_in      (clk_in),
    .sys_rst_in  (sys_rst_in),
    .start_in    (start_q),
    .run_in      (run_q),
    .time_sel_in (act_main_q.isense_meas_time_sel),
    .sample_out  (isense_sample_out)
  );

  assign hrdata_out         = rdata_q;
  assign hreadyout_out      = 1'b1;
  assign hresp_out          = HRESP_OKAY;
  assign main_start_out     = start_q;
  assign main_running_out   = run_q;
  assign isense_start_out   = start_q; // RULE8
  assign isense_running_out = run_q;
  assign aux_start_out      = astart_q;
  assign aux_cell_chan_out  = chan_q;
  assign aux_skip_out       = skip_q;
  assign conv_cfg_out = '{shunt_filter_en:       act_main_q.shunt_filter_en, // RULE2
                          cell_filter_en:        act_main_q.cell_filter_en, // RULE3
                          shunt_frontend_detach: act_aux_q.shunt_frontend_detach, // RULE10
                          aux_shunt_isolate:     iso_q,
                          isense_meas_time_sel:  act_main_q.isense_meas_time_sel};

  start_pair_a: assert property ( // RULE4 RULE8
    go |=> main_start_out && isense_start_out ##1 (!main_start_out || $past(go)))
    else $error("start pulse not issued to both converters");
  write_zero_a: assert property ( // RULE7
    wr_main && !hwdata_in[START_BIT] |=> !main_start_out && $stable(act_main_q))
    else $error("write of 0 to start had an effect");
  hold_cfg_a: assert property ( // RULE5
    !go |=> $stable(act_main_q) && $stable(act_aux_q))
    else $error("active settings changed without a start");
  read_clear_a: assert property ( // RULE6
    rd_main && !go |=> !main_q.start)
    else $error("start bit not cleared by read");
  single_stop_a: assert property ( // RULE9
    run_q && act_main_q.run_mode == MODE_SINGLE && rr_q == 4'h7 && main_rr_done_in && !go |=> !run_q)
    else $error("single run did not stop after eight round robins");
  cont_run_a: assert property ( // RULE9
    run_q && act_main_q.run_mode == MODE_CONT && !go |=> run_q)
    else $error("continuous run stopped without a command");
  mode_idle_a: assert property ( // RULE9
    go && !(main_fwd.run_mode inside {MODE_SINGLE, MODE_CONT}) |=> !run_q)
    else $error("converter running in off or reserved mode");
  filt_load_a: assert property ( // RULE2 RULE3
    go |=> conv_cfg_out.shunt_filter_en == $past(main_fwd.shunt_filter_en)
           && conv_cfg_out.cell_filter_en == $past(main_fwd.cell_filter_en))
    else $error("filter enables not taken at start");
  detach_load_a: assert property ( // RULE10
    go |=> conv_cfg_out.shunt_frontend_detach == $past(aux_fwd.shunt_frontend_detach))
    else $error("detach setting not taken at start");
  lock_first_a: assert property ( // RULE14
    run_q && main_cell1_slot_in && !go && act_aux_q.aux_cell_chan_sel == AUX_SEL_FIRST
    && active_cell_cfg_in[0] |=> aux_start_out && aux_cell_chan_out == 3'h1)
    else $error("lock to channel one failed");
  noshunt_a: assert property ( // RULE13
    run_q && main_cell1_slot_in && !go && act_aux_q.aux_cell_chan_sel == AUX_SEL_NOSHUNT
    |=> aux_skip_out && !aux_start_out && conv_cfg_out.aux_shunt_isolate)
    else $error("shunt not isolated from auxiliary converter");
  rsvd_skip_a: assert property ( // RULE15
    run_q && main_cell1_slot_in && !go && act_aux_q.aux_cell_chan_sel > AUX_SEL_LAST
    |=> aux_skip_out && !aux_start_out)
    else $error("reserved selector did not skip");
  cycle_run_a: assert property ( // RULE12
    run_q && main_cell1_slot_in && !go && act_aux_q.aux_cell_chan_sel == AUX_SEL_CYCLE
    && active_cell_cfg_in != '0 |=> aux_start_out && active_cell_cfg_in[aux_cell_chan_out-3'h1])
    else $error("cycling did not pick an active channel");
  rsvd_zero_a: assert property ( // RULE16
    $past(rd_main) |-> hrdata_out[31:7] == '0)
    else $error("reserved bits read nonzero");
endmodule
`default_nettype wire

// ### design/arc_pkg.sv
package arc_pkg;
  // Register indices; byte address is four times the index
  localparam logic [11:0] MAIN_CTRL_IDX = 12'h30D;
  localparam logic [11:0] AUX_CTRL_IDX  = 12'h30E;
  localparam logic [11:0] STATUS_IDX    = 12'h310;
  localparam logic [7:0]  MAIN_CTRL_RST = 8'h00;
  localparam logic [7:0]  AUX_CTRL_RST  = 8'h00;
  localparam logic [7:0]  CTRL_WMASK    = 8'h7F;
  localparam int          START_BIT     = 2;
  localparam logic        HRESP_OKAY    = 1'b0;

  localparam int          NUM_CELLS      = 6;
  localparam int          CHAN_W         = 3;
  localparam logic [3:0]  RR_SINGLE_RUNS = 4'h8;

  localparam logic [4:0]  AUX_SEL_CYCLE   = 5'h00;
  localparam logic [4:0]  AUX_SEL_NOSHUNT = 5'h01;
  localparam logic [4:0]  AUX_SEL_FIRST   = 5'h02;
  localparam logic [4:0]  AUX_SEL_LAST    = 5'h07;
  localparam logic [4:0]  AUX_SEL_STEP    = 5'h01;

  // Current-sense measurement times
  localparam int unsigned CLK_PERIOD_NS  = 4;
  localparam int unsigned ISENSE_T00_NS  = 768000;
  localparam int unsigned ISENSE_T01_NS  = 1536000;
  localparam int unsigned ISENSE_T10_NS  = 3072000;
  localparam int unsigned ISENSE_T11_NS  = 12288000;
  localparam int unsigned ISENSE_CYC00   = ISENSE_T00_NS / CLK_PERIOD_NS;
  localparam int unsigned ISENSE_CYC01   = ISENSE_T01_NS / CLK_PERIOD_NS;
  localparam int unsigned ISENSE_CYC10   = ISENSE_T10_NS / CLK_PERIOD_NS;
  localparam int unsigned ISENSE_CYC11   = ISENSE_T11_NS / CLK_PERIOD_NS;
  localparam int          ISENSE_CNT_W   = 24;

  typedef enum logic [1:0] {
    MODE_OFF    = 2'b00,
    MODE_SINGLE = 2'b01,
    MODE_CONT   = 2'b10,
    MODE_RSVD   = 2'b11
  } arc_mode_e;

  typedef struct packed {
    logic       rsvd;
    logic [1:0] isense_meas_time_sel;
    logic       shunt_filter_en;
    logic       cell_filter_en;
    logic       start;
    arc_mode_e  run_mode;
  } arc_main_ctrl_s;

  typedef struct packed {
    logic       rsvd;
    logic       shunt_frontend_detach;
    logic       aux_align;
    logic [4:0] aux_cell_chan_sel;
  } arc_aux_ctrl_s;

  typedef struct packed {
    logic [2:0] aux_chan;
    logic [3:0] rr_cnt;
    logic       running;
  } arc_status_s;

  typedef struct packed {
    logic       shunt_filter_en;
    logic       cell_filter_en;
    logic       shunt_frontend_detach;
    logic       aux_shunt_isolate;
    logic [1:0] isense_meas_time_sel;
  } arc_conv_cfg_s;
endpackage

// ### design/arc_isense_timer.sv
`timescale 1ns/1ps
`default_nettype none
module arc_isense_timer #(
  parameter int unsigned CYC00 = arc_pkg::ISENSE_CYC00,
  parameter int unsigned CYC01 = arc_pkg::ISENSE_CYC01,
  parameter int unsigned CYC10 = arc_pkg::ISENSE_CYC10,
  parameter int unsigned CYC11 = arc_pkg::ISENSE_CYC11
) (
  input  wire logic       clk_in,
  input  wire logic       sys_rst_in,
  input  wire logic       start_in,
  input  wire logic       run_in,
  input  wire logic [1:0] time_sel_in,
  output logic            sample_out
);
  import arc_pkg::*;

  logic [ISENSE_CNT_W-1:0] cnt_d;
  logic [ISENSE_CNT_W-1:0] cnt_q;
  logic                    smp_d;
  logic                    smp_q;

  function automatic logic [ISENSE_CNT_W-1:0] last_cnt(input logic [1:0] sel);
    int unsigned cyc;
    unique case (sel)
      2'b00: cyc = CYC00;
      2'b01: cyc = CYC01;
      2'b10: cyc = CYC10;
      2'b11: cyc = CYC11;
    endcase
    return ISENSE_CNT_W'(cyc - 1);
  endfunction

  always_comb begin
    cnt_d = '0;
    smp_d = 1'b0;
    if (!start_in && run_in) begin
      if (cnt_q == last_cnt(time_sel_in)) begin // RULE1
        smp_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      cnt_q <= '0;
      smp_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      smp_q <= smp_d;
    end
  end

  assign sample_out = smp_q;
endmodule
`default_nettype wire

// ### verification/arc_ctrl_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module arc_ctrl_regs_tb_top;
  import arc_pkg::*;
  localparam logic [31:0] MAIN_A = {18'h0, MAIN_CTRL_IDX, 2'b00};
  localparam logic [31:0] AUX_A  = {18'h0, AUX_CTRL_IDX, 2'b00};
  localparam logic [31:0] STAT_A = {18'h0, STATUS_IDX, 2'b00};
  localparam logic [31:0] FREE_A = 32'h0000_0C3C;

  logic          clk_in             = 1'b0;
  logic          sys_rst_in         = 1'b1;
  logic          hsel_in            = 1'b0;
  logic [31:0]   haddr_in           = 32'h0;
  logic [1:0]    htrans_in          = 2'h0;
  logic          hwrite_in          = 1'b0;
  logic [2:0]    hsize_in           = 3'h2;
  logic [31:0]   hwdata_in          = 32'h0;
  logic [5:0]    active_cell_cfg_in = 6'h3F;
  logic          main_rr_done_in    = 1'b0;
  logic          main_cell1_slot_in = 1'b0;
  logic [31:0]   hrdata;
  logic          hready;
  logic          hresp;
  arc_conv_cfg_s cfg;
  logic          main_start;
  logic          main_run;
  logic          is_start;
  logic          is_run;
  logic          is_samp;
  logic          aux_start;
  logic [2:0]    aux_chan;
  logic          aux_skip;
  int            fails;
  int            tests_run;
  int            cyc_n;
  int            n_start;
  int            n_istart;
  int            n_aux;
  int            n_skip;
  int            t_prev;
  int            t_last;
  logic [31:0]   v;

  always #2 clk_in = ~clk_in;

  arc_ctrl_regs #(
    .ISENSE_CYC00(8),
    .ISENSE_CYC01(16),
    .ISENSE_CYC10(32),
    .ISENSE_CYC11(64)
  ) arc_ctrl_regs_inst (
    .clk_in             (clk_in),
    .sys_rst_in         (sys_rst_in),
    .hsel_in            (hsel_in),
    .haddr_in           (haddr_in),
    .htrans_in          (htrans_in),
    .hwrite_in          (hwrite_in),
    .hsize_in           (hsize_in),
    .hwdata_in          (hwdata_in),
    .hready_in          (hready),
    .hrdata_out         (hrdata),
    .hreadyout_out      (hready),
    .hresp_out          (hresp),
    .active_cell_cfg_in (active_cell_cfg_in),
    .main_rr_done_in    (main_rr_done_in),
    .main_cell1_slot_in (main_cell1_slot_in),
    .conv_cfg_out       (cfg),
    .main_start_out     (main_start),
    .main_running_out   (main_run),
    .isense_start_out   (is_start),
    .isense_running_out (is_run),
    .isense_sample_out  (is_samp),
    .aux_start_out      (aux_start),
    .aux_cell_chan_out  (aux_chan),
    .aux_skip_out       (aux_skip)
  );

  // Event counters seen at each rising edge
  always @(posedge clk_in) begin
    cyc_n++;
    if (main_start === 1'b1) n_start++;
    if (is_start === 1'b1) n_istart++;
    if (aux_start === 1'b1) n_aux++;
    if (aux_skip === 1'b1) n_skip++;
    if (is_samp === 1'b1) begin
      t_prev = t_last;
      t_last = cyc_n;
    end
  end

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen 0x%08h expected 0x%08h", $time, seen, exp);
    end
  endtask

  // Samples ready and read data as they stand at the coming edge
  task automatic bus_wait(output logic [31:0] rd);
    int   n;
    logic rdy;
    n = 0;
    rdy = 1'b0;
    while (rdy !== 1'b1) begin
      if (n == 50) begin
        fails++;
        test_done();
      end
      @(negedge clk_in);
      rdy = hready;
      rd = hrdata;
      @(posedge clk_in);
      n++;
    end
  endtask

  task automatic ahb_xfer(input logic [31:0] a, input logic wr, input logic [31:0] wd, output logic [31:0] rd);
    hsel_in <= 1'b1;
    haddr_in <= a;
    htrans_in <= 2'b10;
    hwrite_in <= wr;
    bus_wait(rd);
    htrans_in <= 2'b00;
    hsel_in <= 1'b0;
    hwdata_in <= wd;
    bus_wait(rd);
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] junk;
    ahb_xfer(a, 1'b1, d, junk);
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    ahb_xfer(a, 1'b0, 32'h0, d);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  task automatic pulse_rr(input int n);
    repeat (n) begin
      main_rr_done_in <= 1'b1;
      @(posedge clk_in);
      main_rr_done_in <= 1'b0;
      @(posedge clk_in);
    end
  endtask

  // Expected event: 2 conversion, 1 skip, 0 nothing
  task automatic aux_slot(input int ev, input logic [2:0] chan);
    int a0;
    int s0;
    a0 = n_aux;
    s0 = n_skip;
    main_cell1_slot_in <= 1'b1;
    @(posedge clk_in);
    main_cell1_slot_in <= 1'b0;
    cyc(3);
    check(32'((n_aux - a0) * 2 + (n_skip - s0)), 32'(ev));
    if (ev == 2) check({29'h0, aux_chan}, {29'h0, chan});
  endtask

  task automatic run_chk(input logic on);
    check({30'h0, main_run, is_run}, on ? 32'h3 : 32'h0);
  endtask

  initial begin
    int s0;
    cyc(10);
    sys_rst_in <= 1'b0;
    rd(MAIN_A, v);
    check(v, {24'h0, MAIN_CTRL_RST});
    rd(AUX_A, v);
    check(v, {24'h0, AUX_CTRL_RST});
    rd(STAT_A, v);
    check(v, 32'h0);
    rd(FREE_A, v);
    check(v, 32'h0);
    check({26'h0, cfg}, 32'h0);
    run_chk(1'b0);
    $display("test reset done");

    wr(AUX_A, 32'hFFFF_FFFF);
    rd(AUX_A, v);
    check(v, 32'h7F);
    wr(MAIN_A, 32'hFB);
    rd(MAIN_A, v);
    check(v, 32'h7B);
    check(32'(n_start), 32'h0);
    run_chk(1'b0);
    check({26'h0, cfg}, 32'h0);
    $display("test reserved done");

    wr(AUX_A, 32'h43);
    wr(MAIN_A, 32'h35);
    rd(MAIN_A, v);
    check(v, 32'h35);
    rd(MAIN_A, v);
    check(v, 32'h31);
    check(32'(n_start), 32'h1);
    check(32'(n_istart), 32'h1);
    run_chk(1'b1);
    check({26'h0, cfg}, 32'h29);
    aux_slot(2, 3'h2);
    wr(AUX_A, 32'h01);
    wr(MAIN_A, 32'h09);
    check({26'h0, cfg}, 32'h29);
    aux_slot(2, 3'h2);
    pulse_rr(7);
    run_chk(1'b1);
    pulse_rr(1);
    cyc(2);
    run_chk(1'b0);
    aux_slot(0, 3'h0);
    $display("test single done");

    wr(MAIN_A, 32'h0D);
    cyc(2);
    check({26'h0, cfg}, 32'h14);
    aux_slot(1, 3'h0);
    active_cell_cfg_in <= 6'b101001;
    wr(AUX_A, 32'h00);
    wr(MAIN_A, 32'h06);
    aux_slot(2, 3'h1);
    aux_slot(2, 3'h4);
    aux_slot(2, 3'h6);
    aux_slot(2, 3'h1);
    for (int i = 2; i <= 7; i++) begin
      wr(AUX_A, 32'(i));
      wr(MAIN_A, 32'h06);
      aux_slot(active_cell_cfg_in[i-2] ? 2 : 1, 3'(i - 1));
    end
    for (int i = 8; i <= 31; i += 11) begin
      wr(AUX_A, 32'(i));
      wr(MAIN_A, 32'h06);
      aux_slot(1, 3'h0);
    end
    $display("test aux done");

    for (int s = 0; s < 4; s++) begin
      wr(MAIN_A, {25'h0, 2'(s), 5'b00110});
      cyc(3 * (8 << s) + 6);
      check(32'(t_last - t_prev), 32'(8 << s));
      check({30'h0, cfg.isense_meas_time_sel}, 32'(s));
    end
    $display("test isense done");

    s0 = n_start;
    wr(MAIN_A, 32'h07);
    cyc(2);
    check(32'(n_start - s0), 32'h1);
    run_chk(1'b0);
    wr(MAIN_A, 32'h06);
    cyc(2);
    run_chk(1'b1);
    cyc(40);
    run_chk(1'b1);
    wr(MAIN_A, 32'h04);
    cyc(2);
    run_chk(1'b0);
    check({31'h0, hresp}, {31'h0, HRESP_OKAY});
    $display("test modes done");
    test_done();
  end
endmodule
`default_nettype wire
